// ### src/irq_status_vector.v
// Purpose: Two-bank interrupt pending, mask, status and vector logic behind AHB-Lite
// Assumes: Interrupt inputs active low, asynchronous to hclk
// Notes:   Zero-wait-state slave; all responses OKAY
//          Read side effects land at the edge that closes the data phase
//          Interrupt output is a registered level, high while a masked bank event is set
`include "irq_consts.vh"

module irq_status_vector #(
  parameter W       = 16,
  parameter FRAME_W = 16
) (
  input  wire                hclk,
  input  wire                hresetn,
  input  wire                clk_en,
  // AHB-Lite slave side
  input  wire                hsel,
  input  wire [31:0]         haddr,
  input  wire [1:0]          htrans,
  input  wire                hwrite,
  input  wire [2:0]          hsize,
  input  wire [31:0]         hwdata,
  input  wire                hready,
  output reg  [31:0]         hrdata,
  output reg                 hreadyout,
  output reg                 hresp,
  // Interrupt sources, active low
  input  wire [W-1:0]        irq_lo_n,
  input  wire [W-1:0]        irq_hi_n,
  // Frame copied on transfer exceptions
  input  wire [FRAME_W-1:0]  master_frame,
  // Level interrupt to the host
  output reg                 irq
);

  ////////////////////////////////////////////////////////////////////////
  // Address phase capture
  reg                  wr_pend_q;
  reg                  rd_pend_q;
  reg [`ADDR_W-1:0]    addr_q;
  wire                 take = hsel & hready & htrans[`HTRANS_NONSEQ_BIT];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= {`ADDR_W{1'b0}};
    end else if (clk_en) begin
      wr_pend_q <= take & hwrite;
      rd_pend_q <= take & ~hwrite;
      if (take) begin
        addr_q <= haddr[`ADDR_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Input sampling
  // Reset to idle high, so a source held low at release makes one event
  reg  [W-1:0] s1_lo_q;
  reg  [W-1:0] s2_lo_q;
  reg  [W-1:0] s3_lo_q;
  reg  [W-1:0] s1_hi_q;
  reg  [W-1:0] s2_hi_q;
  reg  [W-1:0] s3_hi_q;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_lo_q <= {W{1'b1}};
      s2_lo_q <= {W{1'b1}};
      s3_lo_q <= {W{1'b1}};
      s1_hi_q <= {W{1'b1}};
      s2_hi_q <= {W{1'b1}};
      s3_hi_q <= {W{1'b1}};
    end else if (clk_en) begin
      s1_lo_q <= irq_lo_n;
      s2_lo_q <= s1_lo_q;
      s3_lo_q <= s2_lo_q;
      s1_hi_q <= irq_hi_n;
      s2_hi_q <= s1_hi_q;
      s3_hi_q <= s2_hi_q;
    end
  end

  // Edge taken between second and third stage: first stage is metastability guard only
  wire [W-1:0] ev_lo = s3_lo_q & ~s2_lo_q;
  wire [W-1:0] ev_hi = s3_hi_q & ~s2_hi_q;

  ////////////////////////////////////////////////////////////////////////
  // Registers
  reg  [W-1:0]          pend_lo_q;
  reg  [W-1:0]          pend_hi_q;
  reg  [W-1:0]          mask_lo_q;
  reg  [W-1:0]          mask_hi_q;
  reg  [W-1:0]          stat_lo_q;
  reg  [W-1:0]          stat_hi_q;
  reg                   frz_lo_q;
  reg                   frz_hi_q;
  reg  [FRAME_W-1:0]    frame_q;
  reg  [1:0]            ev_stat_q;
  reg  [1:0]            ev_mask_q;

  ////////////////////////////////////////////////////////////////////////
  // One encoder per bank, fed straight from the status flops
  wire                  vld_lo;
  wire                  vld_hi;
  wire [`VEC_IDX_W-1:0] idx_lo;
  wire [`VEC_IDX_W-1:0] idx_hi;

  prio_encoder16 #(.W(W)) u_enc_lo (
    .status (stat_lo_q),
    .valid  (vld_lo),
    .index  (idx_lo)
  );

  prio_encoder16 #(.W(W)) u_enc_hi (
    .status (stat_hi_q),
    .valid  (vld_hi),
    .index  (idx_hi)
  );

  ////////////////////////////////////////////////////////////////////////
  // Data-phase decode
  // Actions use the captured address, since hwdata only stands a cycle later
  wire         wr = wr_pend_q;
  wire         rd = rd_pend_q;
  wire [W-1:0] wd = hwdata[W-1:0];

  wire wr_pend_lo = wr && addr_q == `OFF_PEND_LO;
  wire wr_pend_hi = wr && addr_q == `OFF_PEND_HI;
  wire wr_stat_lo = wr && addr_q == `OFF_STAT_LO;
  wire wr_stat_hi = wr && addr_q == `OFF_STAT_HI;
  wire rd_stat_lo = rd && addr_q == `OFF_STAT_LO;
  wire rd_stat_hi = rd && addr_q == `OFF_STAT_HI;
  wire rd_vec_lo  = rd && addr_q == `OFF_VEC_LO;
  wire rd_vec_hi  = rd && addr_q == `OFF_VEC_HI;
  wire wr_vec_lo  = wr && addr_q == `OFF_VEC_LO;
  wire wr_vec_hi  = wr && addr_q == `OFF_VEC_HI;
  wire rd_evstat  = rd && addr_q == `OFF_IRQ_STAT;
  wire wr_mask_lo = wr && addr_q == `OFF_MASK_LO;
  wire wr_mask_hi = wr && addr_q == `OFF_MASK_HI;
  wire wr_ev_mask = wr && addr_q == `OFF_IRQ_MASK;

  ////////////////////////////////////////////////////////////////////////
  // Vector read acknowledge: clear the reported bit
  wire [W-1:0] one_lsb = {{(W-1){1'b0}}, 1'b1};
  wire [W-1:0] ack_lo  = (rd_vec_lo && vld_lo) ?
                         (one_lsb << idx_lo) :
                         {W{1'b0}};
  wire [W-1:0] ack_hi  = (rd_vec_hi && vld_hi) ?
                         (one_lsb << idx_hi) :
                         {W{1'b0}};

  ////////////////////////////////////////////////////////////////////////
  // Pending: events and host writes; an event in the write cycle still lands
  wire [W-1:0] pend_lo_d = (wr_pend_lo ? wd : pend_lo_q) | ev_lo;
  wire [W-1:0] pend_hi_d = (wr_pend_hi ? wd : pend_hi_q) | ev_hi;

  ////////////////////////////////////////////////////////////////////////
  // Propagation per bank, each gated by its own mask and its own freeze
  // A frozen bank keeps its events in pending, so none are lost
  wire [W-1:0] pass_lo = frz_lo_q ? {W{1'b0}} : (pend_lo_q & mask_lo_q);
  wire [W-1:0] pass_hi = frz_hi_q ? {W{1'b0}} : (pend_hi_q & mask_hi_q);

  wire [W-1:0] keep_lo = stat_lo_q & (wr_stat_lo ? wd : {W{1'b1}}) & ~ack_lo;
  wire [W-1:0] keep_hi = stat_hi_q & (wr_stat_hi ? wd : {W{1'b1}}) & ~ack_hi;

  // New propagation beats a clear in the same cycle
  wire [W-1:0] stat_lo_d = keep_lo | pass_lo;
  wire [W-1:0] stat_hi_d = keep_hi | pass_hi;

  ////////////////////////////////////////////////////////////////////////
  // Bank events for the output interrupt
  wire [1:0] bank_ev = {|pass_hi, |pass_lo};
  wire       exc_ev  = |(ev_lo & `EXC_MASK);
  // Sticky bank events; new event beats the clear-on-read
  wire [1:0] ev_stat_d = (rd_evstat ? 2'b00 : ev_stat_q) | bank_ev;

  ////////////////////////////////////////////////////////////////////////
  // Pending, mask and status
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_lo_q <= `RST_16;
      pend_hi_q <= `RST_16;
      mask_lo_q <= `RST_16;
      mask_hi_q <= `RST_16;
      stat_lo_q <= `RST_16;
      stat_hi_q <= `RST_16;
    end else if (clk_en) begin
      // Passed bits leave pending so each event reports once
      pend_lo_q <= pend_lo_d & ~pass_lo;
      pend_hi_q <= pend_hi_d & ~pass_hi;
      stat_lo_q <= stat_lo_d;
      stat_hi_q <= stat_hi_d;
      if (wr_mask_lo) begin
        mask_lo_q <= wd;
      end
      if (wr_mask_hi) begin
        mask_hi_q <= wd;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Freeze per bank: a release loses to a read in the same cycle
  // Both cannot coincide on one bus, the order only keeps the logic defined
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frz_lo_q <= 1'b0;
      frz_hi_q <= 1'b0;
    end else if (clk_en) begin
      if (rd_stat_lo || rd_vec_lo) begin
        frz_lo_q <= 1'b1;
      end else if (wr_vec_lo) begin
        frz_lo_q <= 1'b0;
      end
      if (rd_stat_hi || rd_vec_hi) begin
        frz_hi_q <= 1'b1;
      end else if (wr_vec_hi) begin
        frz_hi_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Master frame copy on transfer exceptions; the last one wins
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_q <= {FRAME_W{1'b0}};
    end else if (clk_en && exc_ev) begin
      frame_q <= master_frame;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output interrupt, registered so the pin comes from a flip-flop
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ev_stat_q <= 2'b00;
      ev_mask_q <= 2'b00;
      irq       <= 1'b0;
    end else if (clk_en) begin
      ev_stat_q <= ev_stat_d;
      if (wr_ev_mask) begin
        ev_mask_q <= hwdata[1:0];
      end
      irq <= |(ev_stat_d & ev_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data and handshake
  reg [31:0] rmux;

  always @* begin
    rmux = 32'h0000_0000;
    if (haddr[`ADDR_W-1:0] == `OFF_PEND_LO) begin
      rmux[W-1:0] = pend_lo_q;
    end else if (haddr[`ADDR_W-1:0] == `OFF_PEND_HI) begin
      rmux[W-1:0] = pend_hi_q;
    end else if (haddr[`ADDR_W-1:0] == `OFF_MASK_LO) begin
      rmux[W-1:0] = mask_lo_q;
    end else if (haddr[`ADDR_W-1:0] == `OFF_MASK_HI) begin
      rmux[W-1:0] = mask_hi_q;
    end else if (haddr[`ADDR_W-1:0] == `OFF_STAT_LO) begin
      rmux[W-1:0] = keep_lo | pass_lo;
    end else if (haddr[`ADDR_W-1:0] == `OFF_STAT_HI) begin
      rmux[W-1:0] = keep_hi | pass_hi;
    end else if (haddr[`ADDR_W-1:0] == `OFF_VEC_LO) begin
      rmux[`VEC_VALID_BIT] = |(keep_lo | pass_lo);
      rmux[`VEC_IDX_W-1:0] = idx_next(keep_lo | pass_lo);
    end else if (haddr[`ADDR_W-1:0] == `OFF_VEC_HI) begin
      rmux[`VEC_VALID_BIT] = |(keep_hi | pass_hi);
      rmux[`VEC_IDX_W-1:0] = idx_next(keep_hi | pass_hi);
    end else if (haddr[`ADDR_W-1:0] == `OFF_FRAME_COPY) begin
      rmux[FRAME_W-1:0] = frame_q;
    end else if (haddr[`ADDR_W-1:0] == `OFF_IRQ_STAT) begin
      rmux[1:0] = ev_stat_q | bank_ev;
    end else if (haddr[`ADDR_W-1:0] == `OFF_IRQ_MASK) begin
      rmux[1:0] = ev_mask_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Same encoding as the bank encoders, applied to next-cycle status for read data
  function [`VEC_IDX_W-1:0] idx_next;
    input [W-1:0] s;
    integer k;
    begin
      idx_next = `VEC_NONE;
      for (k = 0; k < W; k = k + 1) begin
        if (s[k]) begin
          idx_next = k[`VEC_IDX_W-1:0];
        end
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Read data registered at address phase; status is presented as it stands after this edge
  // Registering here costs next-cycle status logic, not a wait state, for outputs straight from flops
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (clk_en) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (take && !hwrite) begin
        hrdata <= rmux;
      end
    end
  end

endmodule // irq_status_vector

// ### shared/irq_consts.vh
// Purpose: Register offsets, field positions and reset values of the interrupt status/vector logic
// Assumes: Word-aligned AHB-Lite byte addresses, 32-bit data
// Notes:   Low 12 address bits decoded
`ifndef IRQ_CONSTS_VH
`define IRQ_CONSTS_VH

`define ADDR_W            12
`define OFF_PEND_LO       12'hfb0
`define OFF_PEND_HI       12'hfb4
`define OFF_MASK_LO       12'hfb8
`define OFF_MASK_HI       12'hfbc
`define OFF_STAT_LO       12'hfc0
`define OFF_STAT_HI       12'hfc4
`define OFF_VEC_LO        12'hfc8
`define OFF_VEC_HI        12'hfcc
`define OFF_FRAME_COPY    12'hfd0
`define OFF_IRQ_STAT      12'hfd4
`define OFF_IRQ_MASK      12'hfd8

`define RST_16            16'h0000
`define VEC_VALID_BIT     8
`define VEC_IDX_W         4
`define VEC_NONE          4'h0
// Transfer-exception sources in the low bank: bits 15..12, 8, 7
`define EXC_MASK          16'hf180
`define HTRANS_NONSEQ_BIT 1

`endif

// ### src/prio_encoder16.v
// Purpose: Combinational priority encoder for one status bank
// Assumes: Bit 15 has top priority
// Notes:   No storage; output follows input at once
`include "irq_consts.vh"

module prio_encoder16 #(
  parameter W = 16
) (
  input  wire [W-1:0]            status,
  output reg                     valid,
  output reg  [`VEC_IDX_W-1:0]   index
);

  integer i;

  ////////////////////////////////////////////////////////////////////////
  always @* begin
    valid = |status;
    index = `VEC_NONE;
    for (i = 0; i < W; i = i + 1) begin
      if (status[i]) begin
        index = i[`VEC_IDX_W-1:0];
      end
    end
  end

endmodule // prio_encoder16

// ### verif/irq_status_vector_monitor.sv
// Purpose: Port checker for the interrupt status/vector block
// Assumes: Read data lands one edge after the address
// Notes:   Sees top-level ports only
`include "irq_consts.vh"
module irq_status_vector_monitor (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        clk_en,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_take;
    clk_en && hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence vec_rd;
    rd_take ##0 (haddr[11:0] == `OFF_VEC_LO || haddr[11:0] == `OFF_VEC_HI);
  endsequence
  sequence stat_rd;
    rd_take ##0 (haddr[11:0] == `OFF_STAT_LO || haddr[11:0] == `OFF_STAT_HI);
  endsequence
  sequence gap_rd;
    rd_take ##0 (haddr[11:0] < `OFF_PEND_LO || haddr[11:0] > `OFF_IRQ_MASK);
  endsequence
  a_vec_spare_zero: assert property (vec_rd |=> hrdata[31:9] == 0 && hrdata[7:4] == 0)
    else $error("vector read has stray bits");
  a_vec_empty_idx: assert property (vec_rd |=> hrdata[8] || hrdata[3:0] == 0)
    else $error("empty vector index not zero");
  a_stat_upper_zero: assert property (stat_rd |=> hrdata[31:16] == 0)
    else $error("status read upper half not zero");
  a_unmapped_zero: assert property (gap_rd |=> hrdata == 0)
    else $error("unmapped read not zero");
  a_data_holds: assert property ($changed(hrdata) |-> $past(clk_en && hsel && hready && htrans[1] && !hwrite))
    else $error("read data moved without a read");
  a_zero_wait: assert property (hreadyout)
    else $error("slave inserted a wait state");
  a_resp_okay: assert property (!hresp)
    else $error("slave response not okay");
  // Events need at least four edges to reach the output
  a_quiet_start: assert property ($rose(hresetn) |-> !irq [*3])
    else $error("interrupt raised straight after reset");
endmodule // irq_status_vector_monitor
////////////////////////////////
bind irq_status_vector irq_status_vector_monitor mon (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hrdata, .hreadyout, .hresp, .irq);

// ### verif/ahb_host_model.sv
// Purpose: Host CPU issuing single AHB-Lite word transfers
// Assumes: One slave whose hreadyout is the bus ready
// Notes:   Write data is scrambled during reads
module ahb_host_model (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h0_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= w ? d : ~hwdata;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
endmodule // ahb_host_model

// ### verif/interrupt_status_vector_logic_tb_top.sv
// Purpose: Self-checking bench for the interrupt status/vector block
// Assumes: Zero-wait slave driven by one host model
// Notes:   Sources pulse low for two cycles
`include "irq_consts.vh"
module interrupt_status_vector_logic_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] irq_lo_n = 16'hffff;
  logic [15:0] irq_hi_n = 16'hffff;
  logic [15:0] master_frame = 16'h0000;
  int          errors = 0;
  int          comparisons = 0;
  always #20 hclk = ~hclk;
  irq_status_vector DUT (.hclk, .hresetn, .clk_en(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .irq_lo_n, .irq_hi_n, .master_frame, .irq);
  ahb_host_model host (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata);
  ////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask
  task rd(input logic [11:0] a, input logic [15:0] e);
    host.xfer(1'b0, a, 32'h0000_0000, q);
    chk(q, {16'h0000, e});
  endtask
  task pulse(input logic [15:0] lo, input logic [15:0] hi);
    @(posedge hclk);
    irq_lo_n <= ~lo;
    irq_hi_n <= ~hi;
    repeat (2) @(posedge hclk);
    irq_lo_n <= 16'hffff;
    irq_hi_n <= 16'hffff;
    repeat (6) @(posedge hclk);
  endtask
  ////////////////////////////////
  task t_reset;
    logic [11:0] regs [5] = '{`OFF_STAT_LO, `OFF_STAT_HI, `OFF_VEC_LO, `OFF_VEC_HI, 12'hf00};
    foreach (regs[i]) rd(regs[i], 16'h0000);
    wr(`OFF_VEC_LO, 32'hffff_ffff);
    wr(`OFF_VEC_HI, 32'hffff_ffff);
  endtask
  task t_prio;
    logic [15:0] vec [5] = '{16'h010f, 16'h010a, 16'h0105, 16'h0100, 16'h0000};
    wr(`OFF_MASK_LO, 32'h0000_ffff);
    wr(`OFF_IRQ_MASK, 32'h0000_0001);
    wr(`OFF_PEND_LO, 32'h0000_8421);
    repeat (6) @(posedge hclk);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    rd(`OFF_IRQ_STAT, 16'h0001);
    foreach (vec[i]) rd(`OFF_VEC_LO, vec[i]);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    wr(`OFF_VEC_LO, 32'h0000_0000);
  endtask
  task t_freeze;
    wr(`OFF_MASK_HI, 32'h0000_ffff);
    rd(`OFF_STAT_HI, 16'h0000);
    pulse(16'h0008, 16'h0204);
    rd(`OFF_STAT_HI, 16'h0000);
    rd(`OFF_STAT_LO, 16'h0008);
    wr(`OFF_VEC_HI, 32'h0000_0000);
    repeat (4) @(posedge hclk);
    rd(`OFF_STAT_HI, 16'h0204);
  endtask
  task t_clear;
    wr(`OFF_STAT_HI, 32'h0000_fdff);
    rd(`OFF_STAT_HI, 16'h0004);
    rd(`OFF_VEC_HI, 16'h0102);
    rd(`OFF_VEC_HI, 16'h0000);
    wr(`OFF_VEC_HI, 32'h0000_0000);
  endtask
  task t_mask;
    wr(`OFF_VEC_LO, 32'h0000_0000);
    wr(`OFF_STAT_LO, 32'h0000_0000);
    wr(`OFF_MASK_LO, 32'h0000_0001);
    wr(`OFF_PEND_LO, 32'h0000_0003);
    repeat (4) @(posedge hclk);
    rd(`OFF_STAT_LO, 16'h0001);
  endtask
  task t_frame;
    wr(`OFF_VEC_LO, 32'h0000_0000);
    master_frame <= 16'h1234;
    wr(`OFF_MASK_LO, 32'h0000_ffff);
    pulse(16'h8000, 16'h0000);
    rd(`OFF_FRAME_COPY, 16'h1234);
    rd(`OFF_VEC_LO, 16'h010f);
    wr(`OFF_IRQ_MASK, 32'h0000_0000);
    repeat (2) @(posedge hclk);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    rd(`OFF_IRQ_STAT, 16'h0003);
  endtask
  ////////////////////////////////
  task end_of_test;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_prio;
    t_freeze;
    t_clear;
    t_mask;
    t_frame;
    end_of_test;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge hclk);
    errors++;
    end_of_test;
  end
endmodule // interrupt_status_vector_logic_tb_top
